/* File: rcai_regs.sv */
/*
 Register bank: second interrupt source, calibration control and status,
 filter trim word, RC oscillator trim result, aux ADC setup and OOK AGC rate.
 Assumes one 200 MHz clock mclk, synchronous active-high sys_rst, a register
 port with one-cycle strobes, and calibration engines on the same clock
 except the battery comparator, which is asynchronous.
*/
// Local design decision: the strobed register port.
// Operation
// - Battery alarm flag sets when battery falls below the software threshold.
// - Command-ready flag sets when the processor can accept a command.
// - Wake-up timeout flag sets when the wake-up timer expires.
// - Serial-port-ready flag sets when the serial interface becomes accessible.
// - Synthesizer trim enable bit starts or stops synthesizer calibration.
// - Filter trim enable bit starts or stops IF filter calibration.
// - Synthesizer done reads one when finished, zero while running.
// - Filter done reads one when finished, zero while running and enabled.
// - Six-bit filter trim word is read-only, valid after calibration completes.
// - Force enable substitutes the software six-bit word for the calibrated word.
// - Sixteen-bit RC trim result reads as high byte then low byte.
// - Input selector and reference level fields steer the aux ADC.
// - Filter mode chooses loop and readback filtering and readback update time.
// - ADC reference power bit resets to one; zero powers it down.
// - Tracking AGC rate resets to 2; rate is symbol rate over 2^(n+1).
// - Acquisition AGC rate sits in bits 2:0, resets to 1.
`include "rcai_params.svh"

module rcai_regs (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    input wire logic battery_low_pin,
    input wire rcai_pkg::rcai_evt_s evt,
    output logic synth_trim_enable,
    input wire logic synth_cal_ok,
    output logic if_filter_trim_enable,
    input wire logic filter_cal_ok,
    input wire logic [5:0] filter_cal_word,
    output logic [5:0] if_filter_trim_word,
    input wire logic rc_cal_valid,
    input wire logic [15:0] rc_cal_value,
    output logic [1:0] adc_input_select,
    output logic [1:0] adc_reference_level,
    output logic adc_reference_power_on,
    output logic [1:0] adc_filter_mode,
    input wire logic adc_sample_valid,
    input wire logic [7:0] adc_sample,
    input wire logic agc_tick,
    output logic [7:0] agc_loop_sample,
    input wire logic ook_symbol_tick,
    input wire logic ook_acquire_phase,
    output logic [2:0] ook_gain_track_rate,
    output logic [2:0] ook_gain_acquire_rate,
    output logic ook_agc_update
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        hit = (a == off);
    endfunction

    // Terminal count for a divide by 2^(n+1)
    function automatic logic [8:0] rate_top(input logic [2:0] n);
        rate_top = 9'((10'h2 << n) - 10'h1);
    endfunction

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    wire wr_src = reg_wr & hit(reg_addr, `RCAI_A_IRQ_SRC);
    wire wr_clr = reg_wr & hit(reg_addr, `RCAI_A_IRQ_CLR);
    wire wr_en = reg_wr & hit(reg_addr, `RCAI_A_IRQ_EN);
    wire wr_cal = reg_wr & hit(reg_addr, `RCAI_A_CAL_CTRL);
    wire wr_frc = reg_wr & hit(reg_addr, `RCAI_A_FWORD_FRC);
    wire wr_alo = reg_wr & hit(reg_addr, `RCAI_A_ADC_LO);
    wire wr_ahi = reg_wr & hit(reg_addr, `RCAI_A_ADC_HI);
    wire wr_ook = reg_wr & hit(reg_addr, `RCAI_A_OOK);
    wire rd_filt = reg_rd & hit(reg_addr, `RCAI_A_ADC_FILT);

    // ------------------------------------------------------------
    // Interrupt source
    // ------------------------------------------------------------
    logic batt_s1_q, batt_s2_q, batt_s3_q;
    logic [7:0] src_q, src_d, irq_en_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            batt_s1_q <= 1'b0;
            batt_s2_q <= 1'b0;
            batt_s3_q <= 1'b0;
        end else begin
            batt_s1_q <= battery_low_pin;
            batt_s2_q <= batt_s1_q;
            batt_s3_q <= batt_s2_q;
        end
    end

    // Only the falling crossing raises the alarm, not the low level
    wire batt_evt = batt_s2_q & ~batt_s3_q;

    wire [7:0] set_vec = {batt_evt, evt.cmd_ready, 1'b0,
        evt.wake_timer_expired_flag, 2'b00, evt.spi_ready,
        evt.cmd_finished};
    // Writes of one clear, on the source itself or on the clear register
    wire [7:0] clr_vec = (wr_src | wr_clr) ? reg_wdata : 8'h00;

    // Set wins over clear in the same cycle
    assign src_d = ((src_q & ~clr_vec) | set_vec) & `RCAI_IRQ_USED;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            src_q <= 8'h00;
            irq_en_q <= 8'h00;
        end else begin
            src_q <= src_d;
            if (wr_en) begin
                irq_en_q <= reg_wdata & `RCAI_IRQ_USED;
            end
        end
    end

    assign irq = |(src_q & irq_en_q);

    // ------------------------------------------------------------
    // Calibration control and status
    // ------------------------------------------------------------
    logic [1:0] cal_ctrl_q;
    logic synth_done_q;
    logic [5:0] cal_word_q;
    logic [6:0] force_q;
    rcai_pkg::rcai_fcal_e fst_q, fst_d;

    assign synth_trim_enable = cal_ctrl_q[`RCAI_B_SYNTH];
    assign if_filter_trim_enable = cal_ctrl_q[`RCAI_B_FILT];
    wire synth_start = wr_cal & reg_wdata[`RCAI_B_SYNTH] & ~synth_trim_enable;

    always_comb begin
        case (fst_q)
            rcai_pkg::RCAI_F_IDLE: fst_d = if_filter_trim_enable ? rcai_pkg::RCAI_F_RUN
                : rcai_pkg::RCAI_F_IDLE;
            rcai_pkg::RCAI_F_RUN: begin
                if (!if_filter_trim_enable) begin
                    fst_d = rcai_pkg::RCAI_F_IDLE;
                end else if (filter_cal_ok) begin
                    fst_d = rcai_pkg::RCAI_F_DONE;
                end else begin
                    fst_d = rcai_pkg::RCAI_F_RUN;
                end
            end
            // Done holds after disable so the word stays marked valid
            rcai_pkg::RCAI_F_DONE: fst_d = (wr_cal & reg_wdata[`RCAI_B_FILT]
                & ~if_filter_trim_enable) ? rcai_pkg::RCAI_F_RUN : rcai_pkg::RCAI_F_DONE;
            default: fst_d = rcai_pkg::RCAI_F_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cal_ctrl_q <= 2'b00;
            fst_q <= rcai_pkg::RCAI_F_IDLE;
            synth_done_q <= 1'b0;
            cal_word_q <= 6'h00;
            force_q <= 7'h00;
        end else begin
            if (wr_cal) begin
                cal_ctrl_q <= reg_wdata[1:0];
            end
            fst_q <= fst_d;
            if (synth_start) begin
                synth_done_q <= 1'b0;
            end else if (synth_trim_enable && synth_cal_ok) begin
                synth_done_q <= 1'b1;
            end
            if (fst_q == rcai_pkg::RCAI_F_RUN && filter_cal_ok && if_filter_trim_enable) begin
                cal_word_q <= filter_cal_word;
            end
            if (wr_frc) begin
                force_q <= reg_wdata[6:0];
            end
        end
    end

    wire filt_done = (fst_q == rcai_pkg::RCAI_F_DONE);
    assign if_filter_trim_word = force_q[0] ? force_q[6:1] : cal_word_q;

    // ------------------------------------------------------------
    // RC oscillator result
    // ------------------------------------------------------------
    logic [15:0] rc_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rc_q <= 16'h0000;
        end else if (rc_cal_valid) begin
            rc_q <= rc_cal_value;
        end
    end

    // ------------------------------------------------------------
    // Aux ADC setup and filtering
    // ------------------------------------------------------------
    logic [7:0] adc_lo_q, adc_hi_q, filt_q, filt_rb_q;

    assign adc_input_select = adc_lo_q[3:2];
    assign adc_reference_level = adc_lo_q[1:0];
    assign adc_reference_power_on = adc_hi_q[`RCAI_B_REFON];
    assign adc_filter_mode = adc_hi_q[6:5];

    // Quarter-step smoothing: cheap, no multiplier, settles in a few samples
    wire [9:0] filt_sum = {2'b00, filt_q} + {2'b00, filt_q} + {2'b00, filt_q}
        + {2'b00, adc_sample};
    wire upd_rb = (adc_filter_mode == `RCAI_FM_ON_READ) ? rd_filt
        : agc_tick;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            adc_lo_q <= `RCAI_RST_ADC_LO;
            adc_hi_q <= `RCAI_RST_ADC_HI;
            filt_q <= 8'h00;
            filt_rb_q <= 8'h00;
            agc_loop_sample <= 8'h00;
        end else begin
            if (wr_alo) begin
                adc_lo_q <= reg_wdata;
            end
            if (wr_ahi) begin
                adc_hi_q <= reg_wdata;
            end
            if (adc_sample_valid) begin
                filt_q <= filt_sum[9:2];
                agc_loop_sample <= (adc_filter_mode == `RCAI_FM_BOTH) ? filt_sum[9:2]
                    : adc_sample;
            end
            if (adc_filter_mode == `RCAI_FM_NONE) begin
                filt_rb_q <= adc_sample;
            end else if (upd_rb) begin
                filt_rb_q <= filt_q;
            end
        end
    end

    // ------------------------------------------------------------
    // OOK AGC update rate
    // ------------------------------------------------------------
    logic [7:0] ook_q;
    logic [8:0] ook_cnt_q;

    assign ook_gain_track_rate = ook_q[5:3];
    assign ook_gain_acquire_rate = ook_q[2:0];
    // Software is trusted to keep track >= acquire; no clamp here
    wire [2:0] ook_sel = ook_acquire_phase ? ook_gain_acquire_rate
        : ook_gain_track_rate;
    wire ook_wrap = ook_symbol_tick & (ook_cnt_q >= rate_top(ook_sel));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ook_q <= `RCAI_RST_OOK;
            ook_cnt_q <= 9'h000;
            ook_agc_update <= 1'b0;
        end else begin
            if (wr_ook) begin
                ook_q <= reg_wdata;
            end
            ook_agc_update <= ook_wrap;
            if (ook_wrap) begin
                ook_cnt_q <= 9'h000;
            end else if (ook_symbol_tick) begin
                ook_cnt_q <= ook_cnt_q + 9'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] rmux;
    always_comb begin
        case (reg_addr)
            `RCAI_A_IRQ_SRC: rmux = src_q;
            `RCAI_A_IRQ_EN: rmux = irq_en_q;
            `RCAI_A_CAL_CTRL: rmux = {6'h00, cal_ctrl_q};
            `RCAI_A_CAL_STAT: rmux = {6'h00, synth_done_q, filt_done};
            `RCAI_A_FWORD_RD: rmux = {2'b00, cal_word_q};
            `RCAI_A_FWORD_FRC: rmux = {1'b0, force_q};
            `RCAI_A_RC_HI: rmux = rc_q[15:8];
            `RCAI_A_RC_LO: rmux = rc_q[7:0];
            `RCAI_A_ADC_LO: rmux = adc_lo_q;
            `RCAI_A_ADC_HI: rmux = adc_hi_q;
            `RCAI_A_OOK: rmux = ook_q;
            `RCAI_A_ADC_FILT: rmux = filt_rb_q;
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rmux;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_batt_fall;
        !batt_s2_q ##1 batt_s2_q;
    endsequence

    a_batt_alarm_set: assert property (@(posedge mclk) disable iff (sys_rst)
        s_batt_fall |=> src_q[`RCAI_B_BATT]) else $error("battery alarm not set");
    a_cmd_ready_set: assert property (@(posedge mclk) disable iff (sys_rst)
        evt.cmd_ready |=> src_q[`RCAI_B_CMDRDY] && (irq || !irq_en_q[`RCAI_B_CMDRDY]))
        else $error("command ready flag missing");
    a_wake_set: assert property (@(posedge mclk) disable iff (sys_rst)
        evt.wake_timer_expired_flag |=> src_q[`RCAI_B_WAKE]) else $error("wake flag missing");
    a_spi_set: assert property (@(posedge mclk) disable iff (sys_rst)
        evt.spi_ready |=> src_q[`RCAI_B_SPI]) else $error("spi ready flag missing");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
        src_q[`RCAI_B_WAKE] && !((wr_src || wr_clr) && reg_wdata[`RCAI_B_WAKE])
        |=> src_q[`RCAI_B_WAKE]) else $error("flag dropped without clear");
    a_unused_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (src_q & ~`RCAI_IRQ_USED) == 8'h00) else $error("unused flag bit set");
    a_synth_enable: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_cal |=> synth_trim_enable == $past(reg_wdata[1])) else $error("synth enable wrong");
    a_filt_enable: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_cal |=> if_filter_trim_enable == $past(reg_wdata[0])) else $error("filter enable wrong");
    a_synth_restart: assert property (@(posedge mclk) disable iff (sys_rst)
        synth_start |=> !synth_done_q) else $error("synth done not cleared");
    a_filt_done: assert property (@(posedge mclk) disable iff (sys_rst)
        fst_q == rcai_pkg::RCAI_F_RUN && if_filter_trim_enable && filter_cal_ok
        |=> filt_done ##0 cal_word_q == $past(filter_cal_word)) else $error("filter done missed");
    a_force_word: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_frc && reg_wdata[0] |=> if_filter_trim_word == $past(reg_wdata[6:1]))
        else $error("force word ignored");
    a_ook_rate: assert property (@(posedge mclk) disable iff (sys_rst)
        ook_agc_update |-> $past(ook_cnt_q) == rate_top($past(ook_sel))) else $error("ook rate wrong");
endmodule

/* File: rcai_params.svh */
/*
 Offsets, field positions and reset values of the radio calibration,
 auxiliary ADC and second interrupt source register bank.
 Assumes a 10-bit byte address space on the register port.
*/
`ifndef RCAI_PARAMS_SVH
`define RCAI_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RCAI_A_IRQ_SRC 10'h337
`define RCAI_A_CAL_CTRL 10'h338
`define RCAI_A_CAL_STAT 10'h339
`define RCAI_A_FWORD_RD 10'h345
`define RCAI_A_FWORD_FRC 10'h346
`define RCAI_A_RC_HI 10'h34f
`define RCAI_A_RC_LO 10'h350
`define RCAI_A_ADC_LO 10'h359
`define RCAI_A_ADC_HI 10'h35a
`define RCAI_A_OOK 10'h35b
`define RCAI_A_IRQ_CLR 10'h3f0
`define RCAI_A_IRQ_EN 10'h3f1
`define RCAI_A_ADC_FILT 10'h3f2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCAI_B_BATT 7
`define RCAI_B_CMDRDY 6
`define RCAI_B_WAKE 4
`define RCAI_B_SPI 1
`define RCAI_B_CMDFIN 0
`define RCAI_IRQ_USED 8'hd3
`define RCAI_B_SYNTH 1
`define RCAI_B_FILT 0
`define RCAI_B_REFON 4

// ----------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------
`define RCAI_RST_ADC_LO 8'h00
`define RCAI_RST_ADC_HI 8'h11
`define RCAI_RST_OOK 8'h11
`define RCAI_FM_NONE 2'h0
`define RCAI_FM_ON_READ 2'h1
`define RCAI_FM_ON_TICK 2'h2
`define RCAI_FM_BOTH 2'h3

`endif

/* File: rcai_pkg.sv */
/*
 Types of the radio calibration and auxiliary ADC register bank.
 Assumes rcai_params.svh supplies the numbers.
*/
package rcai_pkg;
    typedef enum logic [2:0] {
        RCAI_F_IDLE = 3'b001,
        RCAI_F_RUN = 3'b010,
        RCAI_F_DONE = 3'b100
    } rcai_fcal_e;

    typedef struct packed {
        logic cmd_ready;
        logic wake_timer_expired_flag;
        logic spi_ready;
        logic cmd_finished;
    } rcai_evt_s;
endpackage

/* File: rcai_regs_tb.sv */
/*
 Self-checking testbench for the radio calibration, aux ADC and second
 interrupt source register bank (rcai_regs).
 Assumes rcai_params.svh and rcai_pkg are compiled first; one 200 MHz clock.
*/
`include "rcai_params.svh"

module rcai_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    logic battery_low_pin = 1'b0;
    rcai_pkg::rcai_evt_s evt = '0;
    logic synth_trim_enable;
    logic synth_cal_ok = 1'b0;
    logic if_filter_trim_enable;
    logic filter_cal_ok = 1'b0;
    logic [5:0] filter_cal_word = 6'h00;
    logic [5:0] if_filter_trim_word;
    logic rc_cal_valid = 1'b0;
    logic [15:0] rc_cal_value = 16'h0000;
    logic [1:0] adc_input_select;
    logic [1:0] adc_reference_level;
    logic adc_reference_power_on;
    logic [1:0] adc_filter_mode;
    logic adc_sample_valid = 1'b0;
    logic [7:0] adc_sample = 8'h00;
    logic agc_tick = 1'b0;
    logic [7:0] agc_loop_sample;
    logic ook_symbol_tick = 1'b0;
    logic ook_acquire_phase = 1'b0;
    logic [2:0] ook_gain_track_rate;
    logic [2:0] ook_gain_acquire_rate;
    logic ook_agc_update;
    int num_errors = 0;
    int n_tests = 0;
    int upd_cnt = 0;

    always #2.5 mclk = ~mclk;

    // Counts the update pulses, one cycle long each
    always @(posedge mclk) begin
        if (ook_agc_update === 1'b1) begin
            upd_cnt++;
        end
    end

    rcai_regs i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .battery_low_pin(battery_low_pin), .evt(evt),
        .synth_trim_enable(synth_trim_enable), .synth_cal_ok(synth_cal_ok),
        .if_filter_trim_enable(if_filter_trim_enable), .filter_cal_ok(filter_cal_ok),
        .filter_cal_word(filter_cal_word), .if_filter_trim_word(if_filter_trim_word),
        .rc_cal_valid(rc_cal_valid), .rc_cal_value(rc_cal_value),
        .adc_input_select(adc_input_select), .adc_reference_level(adc_reference_level),
        .adc_reference_power_on(adc_reference_power_on), .adc_filter_mode(adc_filter_mode),
        .adc_sample_valid(adc_sample_valid), .adc_sample(adc_sample), .agc_tick(agc_tick),
        .agc_loop_sample(agc_loop_sample), .ook_symbol_tick(ook_symbol_tick),
        .ook_acquire_phase(ook_acquire_phase), .ook_gain_track_rate(ook_gain_track_rate),
        .ook_gain_acquire_rate(ook_gain_acquire_rate), .ook_agc_update(ook_agc_update)
    );

    // ----------------------------------------------------------------
    // Bus and comparison helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Idle cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        chk($sformatf("read %h", a), {8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [9:0] a[10] = '{`RCAI_A_IRQ_SRC, `RCAI_A_CAL_CTRL, `RCAI_A_CAL_STAT,
            `RCAI_A_FWORD_RD, `RCAI_A_FWORD_FRC, `RCAI_A_RC_HI, `RCAI_A_RC_LO,
            `RCAI_A_ADC_LO, `RCAI_A_ADC_HI, `RCAI_A_OOK};
        logic [7:0] e[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            `RCAI_RST_ADC_HI, `RCAI_RST_OOK};
        for (int i = 0; i < 10; i++) begin
            rchk(a[i], e[i]);
        end
        chk("ref power", adc_reference_power_on, 16'h1);
        chk("track rate", ook_gain_track_rate, 16'h2);
        chk("acquire rate", ook_gain_acquire_rate, 16'h1);
        chk("adc input", {adc_input_select, adc_reference_level}, 16'h0);
        chk("irq", irq, 16'h0);
        $display("test reset done");
    endtask

    // Runs before any sample so the filter state is still zero
    task automatic t_adc_filter;
        wr(`RCAI_A_ADC_HI, 8'h71);
        chk("filter mode", adc_filter_mode, 16'h3);
        adc_sample <= 8'h80;
        adc_sample_valid <= 1'b1;
        @(posedge mclk);
        adc_sample_valid <= 1'b0;
        @(posedge mclk);
        chk("loop sample filtered", agc_loop_sample, 16'h20);
        wr(`RCAI_A_ADC_HI, 8'h01);
        chk("ref power off", adc_reference_power_on, 16'h0);
        adc_sample <= 8'h5a;
        adc_sample_valid <= 1'b1;
        @(posedge mclk);
        adc_sample_valid <= 1'b0;
        @(posedge mclk);
        chk("loop sample raw", agc_loop_sample, 16'h5a);
        for (int m = 0; m < 4; m++) begin
            wr(`RCAI_A_ADC_HI, {1'b0, m[1:0], 5'h11});
            chk("filter mode", adc_filter_mode, 16'(m));
            rchk(`RCAI_A_ADC_HI, {1'b0, m[1:0], 5'h11});
        end
        // Mode 3 readback moves on the AGC tick, mode 1 on a readback read
        rchk(`RCAI_A_ADC_FILT, 8'h5a);
        agc_tick <= 1'b1;
        @(posedge mclk);
        agc_tick <= 1'b0;
        @(posedge mclk);
        rchk(`RCAI_A_ADC_FILT, 8'h2e);
        wr(`RCAI_A_ADC_HI, 8'h31);
        adc_sample <= 8'h06;
        adc_sample_valid <= 1'b1;
        agc_tick <= 1'b1;
        @(posedge mclk);
        adc_sample_valid <= 1'b0;
        agc_tick <= 1'b0;
        @(posedge mclk);
        chk("loop sample mode 1", agc_loop_sample, 16'h06);
        rchk(`RCAI_A_ADC_FILT, 8'h2e);
        rchk(`RCAI_A_ADC_FILT, 8'h24);
        $display("test adc filter done");
    endtask

    task automatic t_adc_sel;
        for (int i = 0; i < 16; i++) begin
            wr(`RCAI_A_ADC_LO, 8'(i));
            chk("select and level", {adc_input_select, adc_reference_level}, 16'(i));
            rchk(`RCAI_A_ADC_LO, 8'(i));
        end
        $display("test adc select done");
    endtask

    task automatic t_irq;
        logic [7:0] bits[4] = '{8'h40, 8'h10, 8'h02, 8'h01};
        logic [7:0] acc = 8'h00;
        wr(`RCAI_A_IRQ_EN, 8'hd3);
        for (int i = 0; i < 4; i++) begin
            evt <= rcai_pkg::rcai_evt_s'(4'h8 >> i);
            @(posedge mclk);
            evt <= '0;
            @(posedge mclk);
            acc = acc | bits[i];
            rchk(`RCAI_A_IRQ_SRC, acc);
            chk("irq raised", irq, 16'h1);
        end
        wr(`RCAI_A_IRQ_EN, 8'h00);
        chk("irq masked", irq, 16'h0);
        wr(`RCAI_A_IRQ_EN, 8'h10);
        chk("irq one enabled", irq, 16'h1);
        rchk(`RCAI_A_IRQ_EN, 8'h10);
        wr(`RCAI_A_IRQ_SRC, 8'h6e);
        rchk(`RCAI_A_IRQ_SRC, 8'h11);
        wr(`RCAI_A_IRQ_CLR, 8'hff);
        wr(`RCAI_A_IRQ_SRC, 8'h2c);
        rchk(`RCAI_A_IRQ_SRC, 8'h00);
        chk("irq cleared", irq, 16'h0);
        wr(`RCAI_A_IRQ_EN, 8'h80);
        battery_low_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        rchk(`RCAI_A_IRQ_SRC, 8'h80);
        chk("irq battery", irq, 16'h1);
        wr(`RCAI_A_IRQ_CLR, 8'h80);
        rchk(`RCAI_A_IRQ_SRC, 8'h00);
        battery_low_pin <= 1'b0;
        $display("test interrupts done");
    endtask

    task automatic t_cal;
        wr(`RCAI_A_CAL_CTRL, 8'h03);
        chk("synth enable", synth_trim_enable, 16'h1);
        chk("filter enable", if_filter_trim_enable, 16'h1);
        rchk(`RCAI_A_CAL_STAT, 8'h00);
        filter_cal_word <= 6'h2a;
        filter_cal_ok <= 1'b1;
        synth_cal_ok <= 1'b1;
        @(posedge mclk);
        filter_cal_ok <= 1'b0;
        synth_cal_ok <= 1'b0;
        @(posedge mclk);
        rchk(`RCAI_A_CAL_STAT, 8'h03);
        rchk(`RCAI_A_FWORD_RD, 8'h2a);
        chk("trim word", if_filter_trim_word, 16'h2a);
        wr(`RCAI_A_FWORD_FRC, 8'h2b);
        chk("forced word", if_filter_trim_word, 16'h15);
        rchk(`RCAI_A_FWORD_FRC, 8'h2b);
        rchk(`RCAI_A_FWORD_RD, 8'h2a);
        wr(`RCAI_A_FWORD_FRC, 8'h2a);
        chk("unforced word", if_filter_trim_word, 16'h2a);
        wr(`RCAI_A_CAL_CTRL, 8'h00);
        chk("enables off", {synth_trim_enable, if_filter_trim_enable}, 16'h0);
        // A result outside a running calibration must not move the word
        filter_cal_word <= 6'h11;
        filter_cal_ok <= 1'b1;
        @(posedge mclk);
        filter_cal_ok <= 1'b0;
        @(posedge mclk);
        rchk(`RCAI_A_FWORD_RD, 8'h2a);
        wr(`RCAI_A_CAL_CTRL, 8'h03);
        rchk(`RCAI_A_CAL_STAT, 8'h00);
        wr(`RCAI_A_CAL_CTRL, 8'h00);
        $display("test calibration done");
    endtask

    task automatic t_rc;
        rc_cal_value <= 16'hb36e;
        rc_cal_valid <= 1'b1;
        @(posedge mclk);
        rc_cal_valid <= 1'b0;
        @(posedge mclk);
        rchk(`RCAI_A_RC_HI, 8'hb3);
        rchk(`RCAI_A_RC_LO, 8'h6e);
        wr(`RCAI_A_RC_HI, 8'hff);
        wr(`RCAI_A_FWORD_RD, 8'hff);
        wr(10'h3ff, 8'hff);
        rchk(`RCAI_A_RC_HI, 8'hb3);
        rchk(`RCAI_A_FWORD_RD, 8'h2a);
        rchk(10'h3ff, 8'h00);
        $display("test rc result done");
    endtask

    task automatic count_upd(input logic [15:0] exp);
        upd_cnt = 0;
        repeat (16) begin
            ook_symbol_tick <= 1'b1;
            @(posedge mclk);
            ook_symbol_tick <= 1'b0;
            @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
        chk("agc updates", upd_cnt[15:0], exp);
    endtask

    // Periods grow so the tick counter never passes a shorter limit
    task automatic t_ook;
        wr(`RCAI_A_OOK, 8'h08); // tracking kept at or above acquisition
        chk("rates", {ook_gain_track_rate, ook_gain_acquire_rate}, 16'h08);
        rchk(`RCAI_A_OOK, 8'h08);
        ook_acquire_phase <= 1'b1;
        count_upd(16'd8);
        ook_acquire_phase <= 1'b0;
        count_upd(16'd4);
        wr(`RCAI_A_OOK, 8'h11);
        count_upd(16'd2);
        $display("test ook rate done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_adc_filter();
        t_adc_sel();
        t_irq();
        t_cal();
        t_rc();
        t_ook();
        finish_test();
    end

    // The whole run needs about 340 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        finish_test();
    end
endmodule
